// >>> hdl/gpx_pin_ctrl.sv
// Purpose: pad control of one port pin
// Assumes: direction and output bits come from registers with async reset
// Notes:   purely combinational, so the pad follows reset with no clock
`timescale 1ns/1ps
module gpx_pin_ctrl
(
   // configuration
   input  wire logic dir_bit,
   input  wire logic out_bit,
   input  wire logic pullup_disable,
   // sleep clamp
   input  wire logic sleep_clamp,
   input  wire logic ext_int_enable,
   // pad side
   input  wire logic pad_in,
   output logic      pad_oe,
   output logic      pad_drive,
   output logic      pad_pullup,
   output logic      digital_in
);
   // driver and pull-up: pull-up only as a plain input with no global disable
   assign pad_oe     = dir_bit;
   assign pad_drive  = out_bit;
   assign pad_pullup = ~dir_bit & out_bit & ~pullup_disable;
   // clamp to ground ahead of the input stage unless the interrupt needs it
   assign digital_in = pad_in & ~(sleep_clamp & ~ext_int_enable);
endmodule

// >>> hdl/gpx_pkg.sv
// Purpose: shared constants for the general-purpose port pin block
// Assumes: one 8-bit port, APB slave with 32-bit data, 10 MHz clock
// Notes:   offsets are byte addresses of aligned words
package gpx_pkg;
   // port geometry
   localparam int          GPX_PINS         = 8;
   // register byte offsets
   localparam logic [7:0]  GPX_ADDR_INPUT   = 8'h00;
   localparam logic [7:0]  GPX_ADDR_DIR     = 8'h04;
   localparam logic [7:0]  GPX_ADDR_OUTPUT  = 8'h08;
   localparam logic [7:0]  GPX_ADDR_CTRL    = 8'h0C;
   // field position of the global pull-up disable in the control register
   localparam int          GPX_PUD_BIT      = 6;
   // reset values
   localparam logic [7:0]  GPX_DIR_RST      = 8'h00;
   localparam logic [7:0]  GPX_OUT_RST      = 8'h00;
   localparam logic [7:0]  GPX_SYNC_RST     = 8'h00;
   localparam logic        GPX_PUD_RST      = 1'b0;
   // synchroniser delay for a software-assigned value, one clock period
   localparam int          GPX_CLK_PERIOD_NS = 100;
   localparam int          GPX_SYNC_DELAY_NS = 100;
   localparam int          GPX_SYNC_CYCLES   = GPX_SYNC_DELAY_NS / GPX_CLK_PERIOD_NS;
endpackage

// >>> hdl/gpx_port.sv
// What this block does
// - three bits per pin, three locations
// - direction one drives, zero inputs
// - input with output one pulls up
// - clear output or set direction: no pull-up
// - reset tri-states pins without a clock
// - output pin drives the output bit
// - global disable kills every pull-up
// - input bit reads pin in any direction
// - first stage latch open while clock high
// - flop captures latch at next rising edge
// - written value readable one period later
// - sleep clamp forces digital input low
// - enabled external interrupt overrides clamp
// - clamp release gives edge to interrupt logic
// - strobes per port, clamp and disable shared
// - input location read-only, others read/write
// - global disable bit 6, resets zero
//
// Purpose: one 8-bit bidirectional port with APB register access
// Assumes: APB master, pads resolved outside from enable and drive
// Notes:   the control register holds only the pull-up disable bit here
`timescale 1ns/1ps
module gpx_port
   import gpx_pkg::*;
(
   // clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // sleep controller and interrupt enables
   input  wire logic        SLEEP_CLAMP,
   input  wire logic [7:0]  EXT_INT_ENABLE,
   // pads
   input  wire logic [7:0]  PAD_IN,
   output logic      [7:0]  PAD_OUT,
   output logic      [7:0]  PAD_OE,
   output logic      [7:0]  PAD_PULLUP,
   output logic      [7:0]  DIGITAL_IN,
   // pull-up disable seen by the other ports of the device
   output logic             PULLUP_DISABLE
);
   logic [7:0]  port_direction_reg;
   logic [7:0]  port_output_reg;
   logic [7:0]  port_input_reg;
   logic        global_pullup_disable;
   logic [31:0] prdata_reg;
   logic        sel_input;
   logic        sel_dir;
   logic        sel_output;
   logic        sel_ctrl;
   logic        mapped;
   logic        setup_phase;
   logic        access_phase;
   logic        output_reg_write_strobe;
   logic        direction_reg_write_strobe;
   logic        control_write_strobe;
   logic [31:0] read_mux;

   // address decode; misaligned or other addresses are unmapped
   assign sel_input    = PADDR == GPX_ADDR_INPUT;
   assign sel_dir      = PADDR == GPX_ADDR_DIR;
   assign sel_output   = PADDR == GPX_ADDR_OUTPUT;
   assign sel_ctrl     = PADDR == GPX_ADDR_CTRL;
   assign mapped       = sel_input | sel_dir | sel_output | sel_ctrl;
   assign setup_phase  = PSEL & ~PENABLE;
   assign access_phase = PSEL & PENABLE;

   // one write strobe per writable location, shared by all pins of the port
   assign output_reg_write_strobe    = access_phase & PWRITE & sel_output & PSTRB[0];
   assign direction_reg_write_strobe = access_phase & PWRITE & sel_dir & PSTRB[0];
   assign control_write_strobe       = access_phase & PWRITE & sel_ctrl & PSTRB[0];

   // zero wait states; only unmapped addresses err
   assign PREADY  = 1'b1;
   assign PSLVERR = access_phase & ~mapped;

   // direction bits, async reset so the drivers let go at once
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         port_direction_reg <= GPX_DIR_RST;
      else if (direction_reg_write_strobe)
         port_direction_reg <= PWDATA[7:0];
   end

   // output value / pull-up select bits
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         port_output_reg <= GPX_OUT_RST;
      else if (output_reg_write_strobe)
         port_output_reg <= PWDATA[7:0];
   end

   // global pull-up disable; writes to the input location are dropped
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         global_pullup_disable <= GPX_PUD_RST;
      else if (control_write_strobe)
         global_pullup_disable <= PWDATA[GPX_PUD_BIT];
   end

   // read data, sampled in the setup phase and held through access
   always_comb
   begin
      read_mux = 32'h0000_0000;
      if (sel_input)
         read_mux[7:0] = port_input_reg;
      else if (sel_dir)
         read_mux[7:0] = port_direction_reg;
      else if (sel_output)
         read_mux[7:0] = port_output_reg;
      else if (sel_ctrl)
         read_mux[GPX_PUD_BIT] = global_pullup_disable;
   end

   // read data register; the input bit is one cycle old when seen
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         prdata_reg <= 32'h0000_0000;
      else if (setup_phase & ~PWRITE)
         prdata_reg <= read_mux;
   end
   assign PRDATA = prdata_reg;

   // per-pin pad control; the clamp and disable are common to all pins
   for (genvar n = 0; n < GPX_PINS; n++)
   begin : g_pin
      gpx_pin_ctrl u_pin (
         .dir_bit        (port_direction_reg[n]),
         .out_bit        (port_output_reg[n]),
         .pullup_disable (global_pullup_disable),
         .sleep_clamp    (SLEEP_CLAMP),
         .ext_int_enable (EXT_INT_ENABLE[n]),
         .pad_in         (PAD_IN[n]),
         .pad_oe         (PAD_OE[n]),
         .pad_drive      (PAD_OUT[n]),
         .pad_pullup     (PAD_PULLUP[n]),
         .digital_in     (DIGITAL_IN[n])
      );
   end

   // pin level enters through latch and flop whatever the direction
   gpx_sync #(.WIDTH(GPX_PINS)) u_sync (
      .clk (CLOCK),
      .rst (RST),
      .d   (DIGITAL_IN),
      .q   (port_input_reg)
   );

   assign PULLUP_DISABLE = global_pullup_disable;

   // a write of the direction register, then its effect on the drivers
   sequence dir_write_s;
      direction_reg_write_strobe;
   endsequence

   sequence ctrl_write_s;
      control_write_strobe;
   endsequence

   sequence input_write_s;
      access_phase && PWRITE && sel_input;
   endsequence

   sequence read_dir_s;
      setup_phase && !PWRITE && sel_dir ##1 access_phase;
   endsequence

   dir_drives_pins_a : assert property (@(posedge CLOCK) disable iff (RST)
      dir_write_s |=> PAD_OE == $past(PWDATA[7:0]))
      else $error("driver enables do not follow direction write");

   pullup_on_a : assert property (@(posedge CLOCK) disable iff (RST)
      !global_pullup_disable
         |-> PAD_PULLUP == (~port_direction_reg & port_output_reg))
      else $error("pull-up missing on input with output bit set");

   pullup_off_a : assert property (@(posedge CLOCK) disable iff (RST)
      (PAD_PULLUP & (port_direction_reg | ~port_output_reg)) == 8'h00)
      else $error("pull-up on while output bit clear or pin output");

   reset_tristate_a : assert property (@(posedge CLOCK)
      RST |-> PAD_OE == 8'h00 && PAD_PULLUP == 8'h00)
      else $error("pins not released during reset");

   drive_value_a : assert property (@(posedge CLOCK) disable iff (RST)
      $rose(PAD_OE[0]) |-> PAD_OUT[0] == port_output_reg[0] && !PAD_PULLUP[0])
      else $error("output pin not driving its output bit");

   pud_kills_pullups_a : assert property (@(posedge CLOCK) disable iff (RST)
      global_pullup_disable |-> PAD_PULLUP == 8'h00)
      else $error("pull-up active with global disable set");

   sync_delay_a : assert property (@(posedge CLOCK) disable iff (RST)
      !$past(RST) |-> port_input_reg == $past(DIGITAL_IN, GPX_SYNC_CYCLES))
      else $error("input bits not one period behind the pins");

   clamp_low_a : assert property (@(posedge CLOCK) disable iff (RST)
      SLEEP_CLAMP |-> (DIGITAL_IN & ~EXT_INT_ENABLE) == 8'h00)
      else $error("clamped digital input not low");

   clamp_bypass_a : assert property (@(posedge CLOCK) disable iff (RST)
      SLEEP_CLAMP |-> ((DIGITAL_IN ^ PAD_IN) & EXT_INT_ENABLE) == 8'h00)
      else $error("enabled interrupt pin still clamped");

   input_read_only_a : assert property (@(posedge CLOCK) disable iff (RST)
      input_write_s |=> $stable(port_direction_reg) && $stable(port_output_reg))
      else $error("write to input location changed a register");

   pud_write_a : assert property (@(posedge CLOCK) disable iff (RST)
      ctrl_write_s |=> PULLUP_DISABLE == $past(PWDATA[GPX_PUD_BIT]))
      else $error("pull-up disable not taken from bit 6");

   reset_values_a : assert property (@(posedge CLOCK) disable iff (RST)
      $fell(RST) |-> port_direction_reg == 8'h00 && port_output_reg == 8'h00
                     && !global_pullup_disable)
      else $error("registers not zero after reset");

   readback_a : assert property (@(posedge CLOCK) disable iff (RST)
      read_dir_s |-> PRDATA == {24'h000000, $past(port_direction_reg)})
      else $error("direction readback wrong");

   // reads of the other locations, each a setup then an access cycle
   sequence read_input_s;
      setup_phase && !PWRITE && sel_input ##1 access_phase;
   endsequence

   sequence read_output_s;
      setup_phase && !PWRITE && sel_output ##1 access_phase;
   endsequence

   sequence read_ctrl_s;
      setup_phase && !PWRITE && sel_ctrl ##1 access_phase;
   endsequence

   out_write_a : assert property (@(posedge CLOCK) disable iff (RST)
      output_reg_write_strobe |=> port_output_reg == $past(PWDATA[7:0]))
      else $error("output bits do not follow output write");

   input_readback_a : assert property (@(posedge CLOCK) disable iff (RST)
      read_input_s |-> PRDATA == {24'h000000, $past(port_input_reg)})
      else $error("input readback wrong");

   output_readback_a : assert property (@(posedge CLOCK) disable iff (RST)
      read_output_s |-> PRDATA == {24'h000000, $past(port_output_reg)})
      else $error("output readback wrong");

   ctrl_readback_a : assert property (@(posedge CLOCK) disable iff (RST)
      read_ctrl_s
         |-> PRDATA == {25'h0000000, $past(global_pullup_disable), 6'h00})
      else $error("control readback wrong");

   // an unmapped read must err and hand back zero, not stale data
   unmapped_read_a : assert property (@(posedge CLOCK) disable iff (RST)
      (access_phase && !mapped && !PWRITE)
         |-> PSLVERR && PRDATA == 32'h00000000)
      else $error("unmapped read not refused");

   zero_wait_a : assert property (@(posedge CLOCK) disable iff (RST)
      access_phase |-> PREADY)
      else $error("access cycle not answered at once");

   clamp_release_a : assert property (@(posedge CLOCK) disable iff (RST)
      $fell(SLEEP_CLAMP) |-> DIGITAL_IN == PAD_IN)
      else $error("clamp release does not pass the pin level");

   // registers and read data move only when software asks for it;
   // a stray update here would look like a glitch on the pads
   pud_hold_a : assert property (@(posedge CLOCK) disable iff (RST)
      !control_write_strobe |=> $stable(PULLUP_DISABLE))
      else $error("pull-up disable changed without a write");

   dir_hold_a : assert property (@(posedge CLOCK) disable iff (RST)
      !direction_reg_write_strobe |=> $stable(port_direction_reg))
      else $error("direction bits changed without a write");

   out_hold_a : assert property (@(posedge CLOCK) disable iff (RST)
      !output_reg_write_strobe |=> $stable(port_output_reg))
      else $error("output bits changed without a write");

   prdata_hold_a : assert property (@(posedge CLOCK) disable iff (RST)
      !(setup_phase && !PWRITE) |=> $stable(PRDATA))
      else $error("read data changed outside a read setup");
endmodule

// >>> hdl/gpx_sync.sv
// Purpose: two-stage input synchroniser, latch followed by flip-flop
// Assumes: latch open while clk is high, flop loads on rising edge
// Notes:   the latch output feeds only the flop
`timescale 1ns/1ps
module gpx_sync
   import gpx_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] latch_reg;

   // first stage: transparent while clk high, holds while low
   always_latch
   begin
      if (rst)
         latch_reg <= WIDTH'(GPX_SYNC_RST);
      else if (clk)
         latch_reg <= d;
   end

   // second stage: takes the value held since the falling edge
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         q <= WIDTH'(GPX_SYNC_RST);
      else
         q <= latch_reg;
   end
endmodule

// >>> verification/gpx_pad_model.sv
// Purpose: pads and outside circuitry attached to the port pins
// Assumes: external drivers are set by the bench per pin
// Notes:   an undriven pin without pull-up floats as a toggling pattern
`timescale 1ns/1ps
module gpx_pad_model
(
   // clock
   input  wire logic       CLOCK,
   // device side of each pad
   input  wire logic [7:0] PAD_OE,
   input  wire logic [7:0] PAD_OUT,
   input  wire logic [7:0] PAD_PULLUP,
   // external circuit
   input  wire logic [7:0] EXT_EN,
   input  wire logic [7:0] EXT_VAL,
   output logic      [7:0] PAD_IN
);
   logic [7:0] float_pat;

   // a floating pin must not look stable, or a missing pull-up goes unseen
   initial float_pat = 8'hA5;
   always @(posedge CLOCK)
      float_pat <= ~float_pat;

   // device driver wins, then the outside driver, then the pull-up
   always_comb
      for (int i = 0; i < 8; i++)
         PAD_IN[i] = PAD_OE[i] ? PAD_OUT[i] : EXT_EN[i] ? EXT_VAL[i] :
                     PAD_PULLUP[i] ? 1'b1 : float_pat[i];
endmodule

// >>> verification/gpx_port_tb.sv
// Purpose: self-checking bench for the port block
// Assumes: APB master changes signals only just after a rising edge
// Notes:   fine synchroniser timing is left to the design assertions
`timescale 1ns/1ps
module gpx_port_tb;
   import gpx_pkg::*;
   logic        CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic        SLEEP_CLAMP, PULLUP_DISABLE, err;
   logic [7:0]  PADDR, EXT_INT_ENABLE, PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP;
   logic [7:0]  DIGITAL_IN, EXT_EN, EXT_VAL;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [3:0]  PSTRB;
   logic [7:0]  locs [3];
   int          fail_count, checked;

   gpx_port uut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .SLEEP_CLAMP(SLEEP_CLAMP), .EXT_INT_ENABLE(EXT_INT_ENABLE), .PAD_IN(PAD_IN),
      .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .PAD_PULLUP(PAD_PULLUP),
      .DIGITAL_IN(DIGITAL_IN), .PULLUP_DISABLE(PULLUP_DISABLE));

   gpx_pad_model pads (.CLOCK(CLOCK), .PAD_OE(PAD_OE), .PAD_OUT(PAD_OUT),
      .PAD_PULLUP(PAD_PULLUP), .EXT_EN(EXT_EN), .EXT_VAL(EXT_VAL), .PAD_IN(PAD_IN));

   // 10 MHz clock
   initial
   begin
      CLOCK = 1'b0;
      forever #50 CLOCK = ~CLOCK;
   end

   task automatic end_of_test;
   begin
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
   begin
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   end
   endtask

   task automatic check_pin(input logic [7:0] got, input logic [7:0] exp, input string m);
   begin
      check_reg({24'h000000, got}, {24'h000000, exp}, m);
   end
   endtask

   // one transfer; each setup starts from a fresh edge, so there is an idle cycle between
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
   begin
      @(posedge CLOCK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= wd;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      n = 0;
      do
      begin
         @(posedge CLOCK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 16);
      if (PREADY !== 1'b1)
      begin
         fail_count++;
         $display("wrong value at %0t: no ready", $time);
         end_of_test;
      end
      rd      = PRDATA;
      err     = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   end
   endtask

   // main sequence
   initial
   begin
      RST <= 1'b1;   // late in time zero, so the async reset edge is seen
      {PSEL, PENABLE, PWRITE, SLEEP_CLAMP} = 4'b0000;
      {PADDR, EXT_INT_ENABLE} = 16'h0000;
      PWDATA = 32'h00000000;
      PSTRB = 4'hF;
      EXT_EN = 8'h30;
      EXT_VAL = 8'h10;
      fail_count = 0;
      checked = 0;
      locs = '{GPX_ADDR_DIR, GPX_ADDR_OUTPUT, GPX_ADDR_CTRL};
      repeat (4) @(posedge CLOCK);
      RST <= 1'b0;
      @(negedge CLOCK);
      check_pin(PAD_OE, 8'h00, "oe after reset");
      check_pin(PAD_PULLUP, 8'h00, "pull-up after reset");
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b0, locs[i], 32'h00000000);
         check_reg(rd, 32'h00000000, "reset read");
      end
      // output bits first, so the pins pass through the pulled-up input state
      apb(1'b1, GPX_ADDR_OUTPUT, 32'h000000C3);
      @(negedge CLOCK);
      check_pin(PAD_PULLUP, 8'hC3, "pull-up on inputs");
      check_pin(PAD_OE, 8'h00, "still inputs");
      apb(1'b1, GPX_ADDR_DIR, 32'h0000000F);
      @(negedge CLOCK);
      check_pin(PAD_OE, 8'h0F, "output enables");
      check_pin(PAD_OUT & 8'h0F, 8'h03, "drive levels");
      check_pin(PAD_PULLUP, 8'hC0, "pull-up on outputs");
      apb(1'b0, GPX_ADDR_INPUT, 32'h00000000);
      check_reg(rd, 32'h000000D3, "pin readback");
      apb(1'b0, GPX_ADDR_DIR, 32'h00000000);
      check_reg(rd, 32'h0000000F, "direction readback");
      apb(1'b0, GPX_ADDR_OUTPUT, 32'h00000000);
      check_reg(rd, 32'h000000C3, "output readback");
      // pin 6 from pulled-up input to output low through output high, and back
      apb(1'b1, GPX_ADDR_DIR, 32'h0000004F);
      apb(1'b1, GPX_ADDR_OUTPUT, 32'h00000083);
      @(negedge CLOCK);
      check_pin(PAD_OUT & PAD_OE, 8'h03, "pin 6 driven low");
      check_pin(PAD_PULLUP, 8'h80, "pull-up off on output");
      apb(1'b1, GPX_ADDR_DIR, 32'h0000000F);
      apb(1'b1, GPX_ADDR_OUTPUT, 32'h000000C3);
      @(negedge CLOCK);
      check_pin(PAD_PULLUP, 8'hC0, "pull-up restored");
      apb(1'b1, GPX_ADDR_INPUT, 32'h00000000);
      apb(1'b0, GPX_ADDR_INPUT, 32'h00000000);
      check_reg(rd, 32'h000000D3, "input not writable");
      apb(1'b0, 8'h10, 32'h00000000);
      check_reg({31'h00000000, err}, 32'h00000001, "unmapped error");
      check_reg(rd, 32'h00000000, "unmapped read");
      // global disable: pull-ups die, drivers keep going
      apb(1'b1, GPX_ADDR_CTRL, 32'h00000040);
      @(negedge CLOCK);
      check_pin(PAD_PULLUP, 8'h00, "pull-ups disabled");
      check_pin({7'h00, PULLUP_DISABLE}, 8'h01, "shared disable");
      check_pin(PAD_OUT & 8'h0F, 8'h03, "drive with disable");
      apb(1'b0, GPX_ADDR_CTRL, 32'h00000000);
      check_reg(rd, 32'h00000040, "control readback");
      // sleep clamp with interrupts enabled on pins 0 and 7 only
      @(posedge CLOCK);
      EXT_EN <= 8'hF0;
      EXT_VAL <= 8'hF0;
      SLEEP_CLAMP <= 1'b1;
      EXT_INT_ENABLE <= 8'h81;
      @(negedge CLOCK);
      check_pin(DIGITAL_IN, 8'h81, "clamped input");
      apb(1'b0, GPX_ADDR_INPUT, 32'h00000000);
      check_reg(rd, 32'h00000081, "clamped pin read");
      @(posedge CLOCK);
      SLEEP_CLAMP <= 1'b0;
      @(negedge CLOCK);
      check_pin(DIGITAL_IN, 8'hF3, "clamp released");
      // reset raised after an edge must tri-state before the next edge
      @(posedge CLOCK);
      RST <= 1'b1;
      #1;
      check_pin(PAD_OE, 8'h00, "async tri-state");
      check_pin(PAD_PULLUP, 8'h00, "async pull-up off");
      end_of_test;
   end
endmodule
